// File: rtl/sepr_defines.vh
`ifndef SEPR_DEFINES_VH
`define SEPR_DEFINES_VH

// Reference clock period in ns (250 MHz)
`define SEPR_REF_PERIOD_NS  32'h0000_0004
// Self-timed write cycle length in ns, plain default
`define SEPR_WC_NS          32'h004C_4B40
// Instruction codes, plain defaults for the two array instructions
`define SEPR_OP_READ        8'h03
`define SEPR_OP_WRITE       8'h02
// Page geometry
`define SEPR_PAGE_BYTES     32
`define SEPR_PAGE_AW        5
// Received address width on the serial link
`define SEPR_LINK_AW        16
// Decoded address width of the larger density
`define SEPR_ADDR_W         13
// Erased byte value and delivered status bits
`define SEPR_ERASED         8'hFF
`define SEPR_NV_DELIVERED   3'h0
// Field positions of the non-volatile status word
`define SEPR_NV_SWD         2
`define SEPR_NV_BPH         1
`define SEPR_NV_BPL         0

`endif

// File: rtl/sepr_array.v
`timescale 1ns/10ps
`include "sepr_defines.vh"

// Byte array with one registered read port and one write port
module sepr_array #(
	parameter AW = `SEPR_ADDR_W           // Decoded address width
) (
	input  wire          i_ref_clk,    // Reference clock
	input  wire          i_we,         // Write strobe
	input  wire [AW-1:0] i_waddr,      // Write address
	input  wire [7:0]    i_wdata,      // Write data
	input  wire [AW-1:0] i_raddr,      // Read address
	output reg  [7:0]    o_rdata       // Read data, one cycle late
);

	reg [7:0] mem [0:(1<<AW)-1];        // Storage, no reset: contents are non-volatile
	integer   k;                        // Init index

	////////////////////////////////////////////////////////////////////////
	// Delivered state: every byte erased
	initial begin
		for (k = 0; k < (1<<AW); k = k + 1) begin
			mem[k] = `SEPR_ERASED;
		end
		o_rdata = `SEPR_ERASED;
	end

	////////////////////////////////////////////////////////////////////////
	// Write and registered read
	always @(posedge i_ref_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end

endmodule // sepr_array

// File: rtl/sepr_core.v
`timescale 1ns/10ps
`include "sepr_defines.vh"

// Summary of operation
// - Ignore high received address bits per density
// - Read: command, address, then addressed byte out
// - Read advances address after every output byte
// - Read address wraps to zero past top
// - Chip select high stops output, ends read
// - Read refused while write cycle runs
// - Select rise on boundary starts timed write
// - Further write bytes bump only page offset
// - 32-byte page wraps, one write cycle
// - Write needs write enable latch set
// - Write refused while write cycle runs
// - Deselect off byte boundary discards write
// - Write to protected page is refused
// - Power-up deselected; select low at reset release counts as a falling edge
// - Power-up clears latch and busy flag
// - Protect and disable bits survive power cycles
// - Delivered: array FFh, status bits zero
// - Busy flag high during any write cycle
// - Write cycle end clears write enable latch
module sepr_core #(
	parameter        AW       = `SEPR_ADDR_W,   // Decoded address width
	parameter [31:0] WC_NS    = `SEPR_WC_NS,    // Write cycle time in ns
	parameter [7:0]  OP_READ  = `SEPR_OP_READ,  // Array read code
	parameter [7:0]  OP_WRITE = `SEPR_OP_WRITE  // Array write code
) (
	input  wire       i_ref_clk,               // Reference clock, 250 MHz
	input  wire       i_nrst,                  // Async reset, active low
	input  wire       i_spi_cs_n,              // Chip select pin, active low
	input  wire       i_spi_sclk,              // Serial clock pin
	input  wire       i_spi_mosi,              // Serial data in pin
	output reg        o_spi_miso,              // Serial data out
	output reg        o_spi_miso_oe,           // Data out enable
	input  wire       i_wel_set,               // Write-enable decoded, pulse
	input  wire       i_wel_clr,               // Write-disable decoded, pulse
	input  wire       i_sr_wr_start,           // Status write accepted, pulse
	input  wire [2:0] i_sr_wr_data,            // New disable and protect bits
	output reg        o_write_enable_latch,    // Write enable latch
	output reg        o_write_in_progress,     // Self-timed cycle busy
	output reg        o_block_protect_hi,      // Protect field high bit
	output reg        o_block_protect_lo,      // Protect field low bit
	output reg        o_status_write_disable   // Status write disable bit
);

	////////////////////////////////////////////////////////////////////////
	// Constants
	localparam [31:0] WC_CYC = (WC_NS + `SEPR_REF_PERIOD_NS - 32'h0000_0001)
	                           / `SEPR_REF_PERIOD_NS;   // Least time rounds up
	localparam        PW     = `SEPR_PAGE_AW;           // Page offset width
	localparam        NP     = `SEPR_PAGE_BYTES;        // Page size in bytes

	localparam [2:0] ST_IDLE  = 3'h0;  // Deselected
	localparam [2:0] ST_CMD   = 3'h1;  // Shifting the instruction
	localparam [2:0] ST_ADDR  = 3'h2;  // Shifting the address
	localparam [2:0] ST_READ  = 3'h3;  // Streaming array bytes out
	localparam [2:0] ST_WDATA = 3'h4;  // Collecting data bytes
	localparam [2:0] ST_SKIP  = 3'h5;  // Refused, wait for deselect

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge finders
	reg  [2:0] cs_sy_q;         // Select: two sync stages and a history stage
	reg  [2:0] ck_sy_q;         // Serial clock likewise
	reg  [1:0] di_sy_q;         // Data in, two stages
	wire       cs_fall;         // Select went low
	wire       cs_rise;         // Select went high
	wire       ck_rise;         // Serial clock rising
	wire       ck_fall;         // Serial clock falling
	wire       din;             // Synchronised data bit

	// Reset to idle pin levels, so a select held low at power-up reads as a falling edge
	always @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cs_sy_q <= 3'h7;
			ck_sy_q <= 3'h0;
			di_sy_q <= 2'h0;
		end else begin
			cs_sy_q <= {cs_sy_q[1:0], i_spi_cs_n};
			ck_sy_q <= {ck_sy_q[1:0], i_spi_sclk};
			di_sy_q <= {di_sy_q[0], i_spi_mosi};
		end
	end

	// Only stages 1 and 2 feed logic; stage 0 is read by stage 1 alone
	assign cs_fall = cs_sy_q[2] & ~cs_sy_q[1];
	assign cs_rise = ~cs_sy_q[2] & cs_sy_q[1];
	assign ck_rise = ~ck_sy_q[2] & ck_sy_q[1];
	assign ck_fall = ck_sy_q[2] & ~ck_sy_q[1];
	assign din     = di_sy_q[1];

	////////////////////////////////////////////////////////////////////////
	// Protocol state
	reg [2:0]    state_q;       // Command state
	reg [3:0]    bcnt_q;        // Bit count within field
	reg [15:0]   sh_q;          // Input shifter
	reg          is_wr_q;       // Current command is an array write
	reg          wr_ok_q;       // Write still acceptable
	reg          have_byte_q;   // At least one full data byte seen
	reg [AW-1:0] addr_q;        // Internal address counter
	reg [2:0]    obit_q;        // Output bit index
	reg [6:0]    osh_q;         // Output shifter
	reg [NP-1:0] mask_q;        // Page bytes loaded
	reg [AW-PW-1:0] page_q;     // Page under commit
	reg          commit_q;      // Page commit sweep active
	reg [PW-1:0] cidx_q;        // Commit sweep index
	reg [31:0]   wc_cnt_q;      // Write cycle countdown
	reg          sr_pend_q;     // Cycle is a status write
	reg [2:0]    sr_data_q;     // Status value to apply
	reg [2:0]    nv_q;          // Non-volatile status bits

	reg [7:0]    pbuf [0:NP-1]; // Page load buffer

	wire [15:0]  sh_nx;         // Shifter after this bit
	wire [7:0]   rdata;         // Array read data
	wire         pb_we;         // Store a data byte in the page buffer
	wire         cyc_end;       // Last cycle of the timed write
	wire         arr_we;        // Array write strobe
	wire         wr_go;         // Deselect starts a write cycle
	wire         prot;          // Addressed page is protected
	wire [AW-1:0] ain;          // Decoded received address

	assign sh_nx   = {sh_q[14:0], din};
	assign ain     = sh_nx[AW-1:0];
	assign cyc_end = o_write_in_progress && (wc_cnt_q == 32'h0000_0000);
	assign arr_we  = commit_q && mask_q[cidx_q];
	assign pb_we   = (state_q == ST_WDATA) && ck_rise && !cs_rise && !cs_fall
	                 && (bcnt_q[2:0] == 3'h7) && wr_ok_q;
	// Deselect on a byte boundary after a whole byte, everything else discards
	assign wr_go   = cs_rise && (state_q == ST_WDATA) && (bcnt_q == 4'h0)
	                 && have_byte_q && wr_ok_q && !o_write_in_progress;

	// Quarter, half or whole array protected, counted from the top
	assign prot = (nv_q[1:0] == 2'h3) ||
	              ((nv_q[1:0] == 2'h2) && ain[AW-1]) ||
	              ((nv_q[1:0] == 2'h1) && (ain[AW-1:AW-2] == 2'h3));

	////////////////////////////////////////////////////////////////////////
	// Serial command engine
	always @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q       <= ST_IDLE;
			bcnt_q        <= 4'h0;
			sh_q          <= 16'h0000;
			is_wr_q       <= 1'b0;
			wr_ok_q       <= 1'b0;
			have_byte_q   <= 1'b0;
			addr_q        <= {AW{1'b0}};
			obit_q        <= 3'h0;
			osh_q         <= 7'h00;
			o_spi_miso    <= 1'b0;
			o_spi_miso_oe <= 1'b0;
		end else if (cs_rise) begin
			// Deselect ends any command and frees the data out pin
			state_q       <= ST_IDLE;
			o_spi_miso_oe <= 1'b0;
			have_byte_q   <= 1'b0;
		end else if (cs_fall) begin
			state_q     <= ST_CMD;
			bcnt_q      <= 4'h0;
			have_byte_q <= 1'b0;
		end else begin
			case (state_q)
				ST_CMD: begin
					if (ck_rise) begin
						sh_q   <= sh_nx;
						bcnt_q <= bcnt_q + 4'h1;
						if (bcnt_q == 4'h7) begin
							bcnt_q  <= 4'h0;
							is_wr_q <= (sh_nx[7:0] == OP_WRITE);
							// Latch and busy are judged when the code arrives
							wr_ok_q <= o_write_enable_latch && !o_write_in_progress;
							if (sh_nx[7:0] == OP_READ) begin
								state_q <= o_write_in_progress ? ST_SKIP : ST_ADDR;
							end else if (sh_nx[7:0] == OP_WRITE) begin
								state_q <= ST_ADDR;
							end else begin
								// Other codes are handled elsewhere
								state_q <= ST_SKIP;
							end
						end
					end
				end
				ST_ADDR: begin
					if (ck_rise) begin
						sh_q   <= sh_nx;
						bcnt_q <= bcnt_q + 4'h1;
						if (bcnt_q == 4'hF) begin
							addr_q <= ain;
							bcnt_q <= 4'h0;
							obit_q <= 3'h0;
							if (is_wr_q) begin
								state_q <= ST_WDATA;
								wr_ok_q <= wr_ok_q && !prot;
							end else begin
								state_q <= ST_READ;
							end
						end
					end
				end
				ST_READ: begin
					// Data out changes on falling edges; array data is ready long before
					if (ck_fall) begin
						o_spi_miso_oe <= 1'b1;
						obit_q        <= obit_q + 3'h1;
						if (obit_q == 3'h0) begin
							o_spi_miso <= rdata[7];
							osh_q      <= rdata[6:0];
							// Counter width makes the top address roll to zero
							addr_q     <= addr_q + {{(AW-1){1'b0}}, 1'b1};
						end else begin
							o_spi_miso <= osh_q[6];
							osh_q      <= {osh_q[5:0], 1'b0};
						end
					end
				end
				ST_WDATA: begin
					if (ck_rise) begin
						sh_q   <= sh_nx;
						bcnt_q <= {1'b0, bcnt_q[2:0] + 3'h1};
						if (bcnt_q[2:0] == 3'h7) begin
							have_byte_q <= 1'b1;
							// Only the page offset moves, so bytes stay in one page
							addr_q[PW-1:0] <= addr_q[PW-1:0] + {{(PW-1){1'b0}}, 1'b1};
						end
					end
				end
				ST_SKIP: begin
					o_spi_miso_oe <= 1'b0;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Page buffer: later bytes at a wrapped offset overwrite earlier ones
	always @(posedge i_ref_clk) begin
		if (pb_we) begin
			pbuf[addr_q[PW-1:0]] <= sh_nx[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timed write cycle, page commit and write enable latch
	always @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_write_in_progress  <= 1'b0;
			o_write_enable_latch <= 1'b0;
			wc_cnt_q             <= 32'h0000_0000;
			mask_q               <= {NP{1'b0}};
			page_q               <= {(AW-PW){1'b0}};
			commit_q             <= 1'b0;
			cidx_q               <= {PW{1'b0}};
			sr_pend_q            <= 1'b0;
			sr_data_q            <= 3'h0;
		end else begin
			// Mask tracks loaded page bytes; kept while a commit sweeps it
			if (cs_fall && !commit_q) begin
				mask_q <= {NP{1'b0}};
			end else if (pb_we) begin
				mask_q[addr_q[PW-1:0]] <= 1'b1;
			end
			if (wr_go) begin
				// One cycle for the whole page, however many bytes came in
				o_write_in_progress <= 1'b1;
				wc_cnt_q            <= WC_CYC - 32'h0000_0001;
				page_q              <= addr_q[AW-1:PW];
				commit_q            <= 1'b1;
				cidx_q              <= {PW{1'b0}};
				sr_pend_q           <= 1'b0;
			end else if (i_sr_wr_start && o_write_enable_latch && !o_write_in_progress) begin
				// Status write cycle shows busy too
				o_write_in_progress <= 1'b1;
				wc_cnt_q            <= WC_CYC - 32'h0000_0001;
				sr_pend_q           <= 1'b1;
				sr_data_q           <= i_sr_wr_data;
			end else if (cyc_end) begin
				o_write_in_progress <= 1'b0;
				sr_pend_q           <= 1'b0;
			end else if (o_write_in_progress) begin
				wc_cnt_q <= wc_cnt_q - 32'h0000_0001;
			end
			// Commit sweep copies flagged bytes into the array
			if (commit_q && !wr_go) begin
				cidx_q <= cidx_q + {{(PW-1){1'b0}}, 1'b1};
				if (cidx_q == {PW{1'b1}}) begin
					commit_q <= 1'b0;
				end
			end
			// Set wins over any clear in the same cycle
			if (i_wel_set) begin
				o_write_enable_latch <= 1'b1;
			end else if (i_wel_clr || cyc_end) begin
				o_write_enable_latch <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Non-volatile status bits: no reset, so they ride through power cycles
	initial begin
		nv_q = `SEPR_NV_DELIVERED;
	end

	always @(posedge i_ref_clk) begin
		// New values take effect only when the status cycle completes
		if (cyc_end && sr_pend_q) begin
			nv_q <= sr_data_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status outputs registered from the stored bits
	initial begin
		o_status_write_disable = 1'b0;
		o_block_protect_hi     = 1'b0;
		o_block_protect_lo     = 1'b0;
	end

	always @(posedge i_ref_clk) begin
		o_status_write_disable <= nv_q[`SEPR_NV_SWD];
		o_block_protect_hi     <= nv_q[`SEPR_NV_BPH];
		o_block_protect_lo     <= nv_q[`SEPR_NV_BPL];
	end

	////////////////////////////////////////////////////////////////////////
	// Array storage
	sepr_array #(
		.AW (AW)
	) u_array (
		.i_ref_clk (i_ref_clk),
		.i_we      (arr_we),
		.i_waddr   ({page_q, cidx_q}),
		.i_wdata   (pbuf[cidx_q]),
		.i_raddr   (addr_q),
		.o_rdata   (rdata)
	);

endmodule // sepr_core

// File: bench/sepr_core_monitor.sv
`timescale 1ns/10ps

// Port-level checks on the array access core
module sepr_core_monitor #(
	parameter [31:0] WC_NS = 32'h004C_4B40  // Write cycle time in ns
) (
	input wire       i_ref_clk,              // Reference clock
	input wire       i_nrst,                 // Async reset, active low
	input wire       i_spi_cs_n,             // Chip select pin
	input wire       i_spi_sclk,             // Serial clock pin
	input wire       i_spi_mosi,             // Serial data in
	input wire       o_spi_miso,             // Serial data out
	input wire       o_spi_miso_oe,          // Data out enable
	input wire       i_wel_set,              // Latch set pulse
	input wire       i_wel_clr,              // Latch clear pulse
	input wire       i_sr_wr_start,          // Status write pulse
	input wire [2:0] i_sr_wr_data,           // New status bits
	input wire       o_write_enable_latch,   // Write enable latch
	input wire       o_write_in_progress,    // Busy flag
	input wire       o_block_protect_hi,     // Protect high bit
	input wire       o_block_protect_lo,     // Protect low bit
	input wire       o_status_write_disable  // Status write disable
);
	localparam int WC_CYC = (WC_NS + 3) / 4;  // Clocks of one timed cycle
	logic [31:0]   busy_cnt_q;                // Busy clocks seen so far

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	////////////////////////////////////////////////////////////////////////
	// Count busy clocks; the length is judged at the fall, not per edge
	always @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			busy_cnt_q <= 32'h0000_0000;
		end else if (o_write_in_progress) begin
			busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
		end else begin
			busy_cnt_q <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	reset_state_a: assert property (
		$rose(i_nrst) |-> !o_write_enable_latch && !o_write_in_progress && !o_spi_miso_oe)
		else $error("state not clear after reset");
	cycle_length_a: assert property (
		$fell(o_write_in_progress) |-> busy_cnt_q == WC_CYC)
		else $error("timed cycle length wrong");
	cycle_cause_a: assert property (
		$rose(o_write_in_progress) |-> $past(i_sr_wr_start) || $past(i_spi_cs_n))
		else $error("busy rose without deselect or status write");
	latch_end_a: assert property (
		$fell(o_write_in_progress) && !$past(i_wel_set) |-> !o_write_enable_latch)
		else $error("latch not cleared at cycle end");
	latch_set_a: assert property (
		i_wel_set |=> o_write_enable_latch)
		else $error("latch not set");
	status_busy_a: assert property (
		i_sr_wr_start && o_write_enable_latch && !o_write_in_progress |=> o_write_in_progress)
		else $error("status write did not raise busy");
	nv_hold_a: assert property (
		!$past(o_write_in_progress, 2) && !$past(o_write_in_progress) |->
		$stable({o_status_write_disable, o_block_protect_hi, o_block_protect_lo}))
		else $error("status bits moved outside a cycle end");
	out_stop_a: assert property (
		$rose(i_spi_cs_n) |-> ##[1:6] !o_spi_miso_oe)
		else $error("output still enabled after deselect");
	out_start_a: assert property (
		$rose(o_spi_miso_oe) |-> !o_write_in_progress && !i_spi_cs_n)
		else $error("output enabled while busy or deselected");
	miso_edge_a: assert property (
		o_spi_miso_oe && $changed(o_spi_miso) |-> !i_spi_sclk)
		else $error("data out moved while serial clock high");
endmodule // sepr_core_monitor

bind sepr_core sepr_core_monitor #(.WC_NS(WC_NS)) u_mon (.i_ref_clk(i_ref_clk),
	.i_nrst(i_nrst), .i_spi_cs_n(i_spi_cs_n), .i_spi_sclk(i_spi_sclk),
	.i_spi_mosi(i_spi_mosi), .o_spi_miso(o_spi_miso), .o_spi_miso_oe(o_spi_miso_oe),
	.i_wel_set(i_wel_set), .i_wel_clr(i_wel_clr), .i_sr_wr_start(i_sr_wr_start),
	.i_sr_wr_data(i_sr_wr_data), .o_write_enable_latch(o_write_enable_latch),
	.o_write_in_progress(o_write_in_progress), .o_block_protect_hi(o_block_protect_hi),
	.o_block_protect_lo(o_block_protect_lo), .o_status_write_disable(o_status_write_disable));

// File: bench/sepr_spi_host.sv
`timescale 1ns/10ps

// Bus master model; clock idles low between frames (mode 0)
module sepr_spi_host (
	input  wire  i_ref_clk,  // Bench reference clock
	input  wire  i_miso,     // Device data out
	input  wire  i_miso_oe,  // Device drives data out
	output logic o_cs_n,     // Chip select, active low
	output logic o_sclk,     // Serial clock, 80 ns period
	output logic o_mosi      // Serial data in
);
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_mosi = 1'b1;
	end

	// One half period: 10 reference clocks, well above the 3 needed
	task automatic half();
		repeat (10) @(negedge i_ref_clk);
	endtask

	// Falling select edge opens every frame
	task automatic sel();
		@(negedge i_ref_clk);
		o_cs_n = 1'b0;
		half();
	endtask

	// Shift n bits msb first; an undriven output reads as z
	task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
		for (int i = 7; i > 7 - n; i--) begin
			o_mosi = tx[i];
			half();
			o_sclk = 1'b1;
			rx[i] = i_miso_oe ? i_miso : 1'bz;
			half();
			o_sclk = 1'b0;
		end
	endtask

	// Deselect half a period after the last fall
	task automatic desel();
		half();
		o_mosi = ~o_mosi; // Released line shows the inverse
		o_cs_n = 1'b1;
		half();
	endtask
endmodule // sepr_spi_host

// File: bench/testbench.sv
`timescale 1ns/10ps
`include "sepr_defines.vh"

module testbench;
	typedef struct packed { logic [15:0] a; int n; logic [7:0] d; logic [7:0] e; } sepr_row_t;
	logic       i_ref_clk = 1'b0;         // Reference clock
	logic       i_nrst = 1'b0;            // Reset, active low
	logic       i_wel_set = 1'b0;         // Latch set pulse
	logic       i_wel_clr = 1'b0;         // Latch clear pulse
	logic       i_sr_wr_start = 1'b0;     // Status write pulse
	logic [2:0] i_sr_wr_data = 3'h0;      // New status bits
	wire        cs_n, sclk, mosi, miso, oe, write_enable_latch, busy, bph, bpl, swd;
	logic [7:0] mem [0:8191];             // Expected array image
	logic [7:0] r;                        // Scratch received byte
	int         errors = 0;
	int         comparisons = 0;
	int         cycles = 0;               // Clocks since start
	sepr_row_t  rows [4] = '{'{16'h0000, 1, 8'hA5, 8'hA5}, '{16'hE03C, 4, 8'h10, 8'h10},
		'{16'h0050, 40, 8'h40, 8'h60}, '{16'h1FFE, 2, 8'h77, 8'h77}};

	always #2 i_ref_clk = ~i_ref_clk;

	sepr_core #(.WC_NS(32'h0000_04B0)) DUT (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
		.i_spi_cs_n(cs_n), .i_spi_sclk(sclk), .i_spi_mosi(mosi), .o_spi_miso(miso),
		.o_spi_miso_oe(oe), .i_wel_set(i_wel_set), .i_wel_clr(i_wel_clr),
		.i_sr_wr_start(i_sr_wr_start), .i_sr_wr_data(i_sr_wr_data),
		.o_write_enable_latch(write_enable_latch), .o_write_in_progress(busy), .o_block_protect_hi(bph),
		.o_block_protect_lo(bpl), .o_status_write_disable(swd));
	sepr_spi_host host (.i_ref_clk(i_ref_clk), .i_miso(miso), .i_miso_oe(oe),
		.o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));

	////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Hang guard: whole run needs roughly 40k clocks
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 90000) begin
			errors++;
			conclude();
		end
	end

	task automatic pulse_wel();
		@(negedge i_ref_clk) i_wel_set = 1'b1;
		@(negedge i_ref_clk) i_wel_set = 1'b0;
	endtask

	// Wait out a timed cycle, bounded, then expect the latch gone
	task automatic idle();
		for (int k = 0; k < 400 && busy !== 1'b0; k++) @(negedge i_ref_clk);
		chk(busy, 0);
		chk(write_enable_latch, 0);
	endtask

	// Status write through the core; the copies follow one clock after busy drops
	task automatic srw(input logic [2:0] v);
		pulse_wel();
		@(negedge i_ref_clk) {i_sr_wr_start, i_sr_wr_data} = {1'b1, v};
		@(negedge i_ref_clk) i_sr_wr_start = 1'b0;
		idle();
		@(negedge i_ref_clk);
		chk({swd, bph, bpl}, v);
	endtask

	task automatic hdr(input logic [7:0] op, input logic [15:0] a);
		host.sel();
		host.bits(op, 8, r);
		host.bits(a[15:8], 8, r);
		host.bits(a[7:0], 8, r);
	endtask

	// Write frame; the image follows only if the device should accept
	task automatic wr(input logic [15:0] a, input int n, input logic [7:0] d, input bit ok);
		hdr(`SEPR_OP_WRITE, a);
		for (int i = 0; i < n; i++) begin
			host.bits(d + i[7:0], 8, r);
			if (ok) mem[{a[12:5], a[4:0] + i[4:0]}] = d + i[7:0];
		end
		host.desel();
		chk(busy, ok);
	endtask

	// Read frame; a refused read leaves the output undriven
	task automatic rd(input logic [15:0] a, input int n, input bit ok, output logic [7:0] f);
		logic [12:0] p;
		hdr(`SEPR_OP_READ, a);
		for (int i = 0; i < n; i++) begin
			p = a[12:0] + i[12:0];
			host.bits(8'h00, 8, r);
			if (i == 0) f = r;
			chk(r, ok ? mem[p] : 8'hzz);
		end
		host.desel();
		chk(oe, 0);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 8192; i++) mem[i] = 8'hFF;
		repeat (5) @(negedge i_ref_clk);
		chk({write_enable_latch, busy, oe}, 0);
		chk({swd, bph, bpl}, 0);
		i_nrst = 1'b1;
		repeat (4) @(negedge i_ref_clk);
		rd(16'h0800, 2, 1, r);
		// Ordinary writes, each read back through the image
		foreach (rows[k]) begin
			pulse_wel();
			wr(rows[k].a, rows[k].n, rows[k].d, 1);
			idle();
			rd(rows[k].a, rows[k].n > 32 ? 32 : rows[k].n, 1, r);
			chk(r, rows[k].e);
		end
		rd(16'hFFFE, 4, 1, r);
		// Partial read frame ends cleanly
		hdr(`SEPR_OP_READ, 16'h0000);
		host.bits(8'h00, 4, r);
		host.desel();
		chk(oe, 0);
		wr(16'h0200, 1, 8'h11, 0);
		// Deselect three bits into a byte discards the write
		pulse_wel();
		hdr(`SEPR_OP_WRITE, 16'h0220);
		host.bits(8'h33, 8, r);
		host.bits(8'h44, 3, r);
		host.desel();
		chk(busy, 0);
		@(negedge i_ref_clk) i_wel_clr = 1'b1;
		@(negedge i_ref_clk) i_wel_clr = 1'b0;
		chk(write_enable_latch, 0);
		// Write and read both refused while a cycle runs
		pulse_wel();
		wr(16'h0300, 1, 8'h55, 1);
		fork
			hdr(`SEPR_OP_WRITE, 16'h0340);
			begin repeat (40) @(negedge i_ref_clk); pulse_wel(); end
		join
		host.bits(8'h66, 8, r);
		host.desel();
		chk(busy, 0);
		pulse_wel();
		wr(16'h0380, 1, 8'h5A, 1);
		rd(16'h0300, 1, 0, r);
		idle();
		rd(16'h0300, 1, 1, r);
		rd(16'h0340, 1, 1, r);
		// Protect top quarter, then write both sides of it
		srw(3'h1);
		pulse_wel();
		wr(16'h1F00, 1, 8'h99, 0);
		wr(16'h0100, 1, 8'h22, 1);
		idle();
		rd(16'h1F00, 1, 1, r);
		rd(16'h0100, 1, 1, r);
		// Top half protected: the half boundary decides
		srw(3'h2);
		pulse_wel();
		wr(16'h1000, 1, 8'hAA, 0);
		wr(16'h0FE0, 1, 8'hBB, 1);
		idle();
		rd(16'h1000, 1, 1, r);
		rd(16'h0FE0, 1, 1, r);
		// Whole array protected, disable bit set as well
		srw(3'h7);
		pulse_wel();
		wr(16'h0000, 1, 8'hCC, 0);
		rd(16'h0000, 1, 1, r);
		// Second reset keeps the protect field and the disable bit
		pulse_wel();
		@(negedge i_ref_clk) i_nrst = 1'b0;
		repeat (5) @(negedge i_ref_clk);
		chk({write_enable_latch, busy, swd, bph, bpl}, 7);
		i_nrst = 1'b1;
		repeat (4) @(negedge i_ref_clk);
		rd(16'h0000, 1, 1, r);
		conclude();
	end
endmodule // testbench
